// ---- hw/hril_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the host register block
// Assumes: 12-bit byte address, 16-bit data path with two byte lanes
// Notes: Definitions only
`ifndef HRIL_PARAMS_SVH
`define HRIL_PARAMS_SVH

// =====================================================================
// Address map
`define HRIL_OFF_INT 12'h000
`define HRIL_MBX_BASE 12'h080
`define HRIL_MBX_LAST 12'h0fc
`define HRIL_MBX_CH_LSB 2
`define HRIL_MBX_CHANS 32

// =====================================================================
// Interrupt register fields
`define HRIL_INT_EN_BIT 0
`define HRIL_INT_PEND_BIT 1
`define HRIL_INT_REL_BIT 15
`define HRIL_INT_RESET 16'h0000

// =====================================================================
// Access timing, in bus clock cycles
`define HRIL_ACC_CYCLES 8

`endif

// ---- hw/hril_pkg.sv ----
// Purpose: Types shared by the host register block and its submodules
// Assumes: Constants come from hril_params.svh
// Notes: Types only
package hril_pkg;

  // =====================================================================
  // Host target request, captured when the block is idle
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } hril_req_type;

  // Host target answer
  typedef struct packed {
    logic done;
    logic retry;
    logic [15:0] rdata;
  } hril_rsp_type;

  // Conversion result written by the acquisition logic
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [15:0] data;
  } hril_conv_type;

  // =====================================================================
  // Access sequencer, result buffer and interrupt register state
  typedef enum logic [0:0] {HRIL_IDLE, HRIL_BUSY} hril_acc_state_type;

  typedef struct packed {
    hril_acc_state_type st;
    logic [2:0] cnt;
    logic mapped;
    logic busy;
    hril_rsp_type rsp;
  } hril_top_state_type;

  typedef struct packed {
    logic [31:0][1:0][15:0] word;
    logic [31:0][1:0] cnt;
  } hril_mbx_state_type;

  typedef struct packed {
    logic en;
    logic pend;
    logic irq;
  } hril_int_state_type;

endpackage

// ---- hw/hril_mailbox.sv ----
// Purpose: Per-channel result buffers, one deep single ended, two deep differential
// Assumes: One conversion write per cycle at most
// Notes: Read data is the oldest stored value, zero before any write
`timescale 1ns/10ps
`include "hril_params.svh"
module hril_mailbox (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire hril_pkg::hril_conv_type conv,
  input wire logic diff_mode,
  input wire logic rd_pop,
  input wire logic [4:0] rd_chan,
  output logic [15:0] rd_data
);
  import hril_pkg::*;

  hril_mbx_state_type q;
  hril_mbx_state_type d;

  // =====================================================================
  // Buffer update; a read pops only a full buffer in differential mode, moving the second level down
  always_comb
  begin
    d = q;
    if (rd_pop && diff_mode && q.cnt[rd_chan] == 2'h2)
    begin
      d.word[rd_chan][0] = q.word[rd_chan][1];
      d.cnt[rd_chan] = 2'h1;
    end
    if (conv.valid)
    begin
      if (!diff_mode)
      begin
        d.word[conv.chan][0] = conv.data;
        d.cnt[conv.chan] = 2'h1;
      end
      else if (d.cnt[conv.chan] == 2'h2)
      begin
        // Full: the oldest value is lost so the newest is never dropped
        d.word[conv.chan][0] = d.word[conv.chan][1];
        d.word[conv.chan][1] = conv.data;
      end
      else
      begin
        d.word[conv.chan][d.cnt[conv.chan][0]] = conv.data;
        d.cnt[conv.chan] = d.cnt[conv.chan] + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign rd_data = q.word[rd_chan][0];

  property p_se_one_level;
    @(posedge sys_clk) disable iff (!arst_n)
    conv.valid && !diff_mode |=> q.cnt[$past(conv.chan)] == 2'h1;
  endproperty
  a_se_one_level: assert property (p_se_one_level)
    else $error("single ended buffer not one level");

  property p_diff_two_level;
    @(posedge sys_clk) disable iff (!arst_n)
    conv.valid && diff_mode && q.cnt[conv.chan] == 2'h1 && !rd_pop
      |=> q.cnt[$past(conv.chan)] == 2'h2;
  endproperty
  a_diff_two_level: assert property (p_diff_two_level)
    else $error("differential buffer did not take second value");

endmodule // hril_mailbox

// ---- hw/hril_intreg.sv ----
// Purpose: Board interrupt register with enable, pending status and release
// Assumes: Write strobe is one cycle, with byte enables
// Notes: Release is a write-one strobe and never stored
`timescale 1ns/10ps
`include "hril_params.svh"
module hril_intreg (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_stb,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  input wire logic irq_event,
  output logic [15:0] rd_val,
  output logic irq_req
);
  import hril_pkg::*;

  hril_int_state_type q;
  hril_int_state_type d;
  logic release_wr;

  assign release_wr = wr_stb && be[1] && wdata[`HRIL_INT_REL_BIT];

  // =====================================================================
  // Enable, pending and request; a new event beats a release in one cycle
  always_comb
  begin
    d = q;
    if (wr_stb && be[0])
      d.en = wdata[`HRIL_INT_EN_BIT];
    if (release_wr)
      d.pend = 1'b0;
    if (irq_event)
      d.pend = 1'b1;
    d.irq = d.pend && d.en;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  // Unused bits and the release bit read as zero
  always_comb
  begin
    rd_val = `HRIL_INT_RESET;
    rd_val[`HRIL_INT_EN_BIT] = q.en;
    rd_val[`HRIL_INT_PEND_BIT] = q.pend;
  end

  assign irq_req = q.irq;

  property p_release_drops;
    @(posedge sys_clk) disable iff (!arst_n)
    release_wr && !irq_event |=> !irq_req && !rd_val[`HRIL_INT_PEND_BIT];
  endproperty
  a_release_drops: assert property (p_release_drops)
    else $error("release did not remove request");

  property p_irq_held;
    @(posedge sys_clk) disable iff (!arst_n)
    irq_req && !release_wr && !(wr_stb && be[0] && !wdata[`HRIL_INT_EN_BIT]) |=> irq_req;
  endproperty
  a_irq_held: assert property (p_irq_held)
    else $error("request dropped without release or disable");

  property p_irq_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    irq_req |-> rd_val[`HRIL_INT_PEND_BIT] && rd_val[`HRIL_INT_EN_BIT];
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request without pending and enable");

  property p_unused_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_val[15:2] == 14'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused interrupt bits not zero");

  property p_event_pends;
    @(posedge sys_clk) disable iff (!arst_n)
    irq_event ##1 rd_val[`HRIL_INT_EN_BIT] |-> irq_req;
  endproperty
  a_event_pends: assert property (p_event_pends)
    else $error("event not pending");

endmodule // hril_intreg

// ---- hw/hril_top.sv ----
// Purpose: Host target register access, result buffers and board interrupt
// Assumes: Host holds off new requests while busy is high
// Notes: Every access answers after a fixed span, except a colliding buffer read
//
// What this block does
// - Reads of unassigned addresses in the map return zero.
// - Every access except a colliding buffer read completes in a fixed span of eight clock cycles.
// - Buffer read colliding with a hardware write ends without data; host retries.
// - Buffer holds one value single ended, two values differential.
// - Low byte sits at the even address, high byte at the odd one.
// - Interrupt register at offset zero takes 8-bit or 16-bit accesses.
// - Reset clears every interrupt register bit.
// - Bit 0 enables board interrupts; zero suppresses them all.
// - Bit 1 reads one while an interrupt is pending.
// - Request driven only when pending and enable are both set.
// - Writing one to bit 15 removes the active request.
// - A raised request stays until release or disable.
// - Bits 2 to 14 ignore writes and read as zero.
`timescale 1ns/10ps
`include "hril_params.svh"
module hril_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire hril_pkg::hril_req_type req,
  input wire hril_pkg::hril_conv_type conv,
  input wire logic irq_event,
  input wire logic diff_mode,
  output logic busy,
  output hril_pkg::hril_rsp_type rsp,
  output logic irq_req
);
  import hril_pkg::*;

  // Cycle count at which the done pulse is set up, so it shows in the last cycle
  localparam logic [2:0] DONE_AT = 3'(`HRIL_ACC_CYCLES - 2);

  hril_top_state_type q;
  hril_top_state_type d;

  logic is_int;
  logic is_mbx;
  logic [4:0] chan;
  logic collide;
  logic take;
  logic int_wr;
  logic mbx_pop;
  logic [15:0] int_val;
  logic [15:0] mbx_val;
  logic [15:0] raw;
  logic [15:0] lane;

  // =====================================================================
  // Address decode; bit 0 is ignored and byte enables pick the lane, so both bytes hit one location
  assign is_int = req.addr[11:1] == 11'(`HRIL_OFF_INT >> 1);
  // Compare word addresses so the odd byte of the last buffer decodes too
  assign is_mbx = {req.addr[11:2], 2'b00} >= `HRIL_MBX_BASE
    && {req.addr[11:2], 2'b00} <= `HRIL_MBX_LAST && !req.addr[1];
  assign chan = req.addr[`HRIL_MBX_CH_LSB +: 5];

  // Collision only when the same buffer is written in the very take cycle
  assign collide = !req.write && is_mbx && conv.valid && conv.chan == chan;
  assign take = q.st == HRIL_IDLE && req.valid;
  assign int_wr = take && req.write && is_int;
  assign mbx_pop = take && !req.write && is_mbx && !collide;

  // =====================================================================
  // Read data mux and byte lanes
  always_comb
  begin
    if (is_int)
      raw = int_val;
    else if (is_mbx)
      raw = mbx_val;
    else
      raw = 16'h0000;
    lane = 16'h0000;
    if (req.be[0])
      lane[7:0] = raw[7:0];
    if (req.be[1])
      lane[15:8] = raw[15:8];
  end

  // =====================================================================
  // Result buffers
  hril_mailbox u_mailbox (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .conv(conv),
    .diff_mode(diff_mode),
    .rd_pop(mbx_pop),
    .rd_chan(chan),
    .rd_data(mbx_val)
  );

  // Interrupt register
  hril_intreg u_intreg (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_stb(int_wr),
    .be(req.be),
    .wdata(req.wdata),
    .irq_event(irq_event),
    .rd_val(int_val),
    .irq_req(irq_req)
  );

  // =====================================================================
  // Access sequencer; data is sampled at take, so a later conversion
  // write cannot tear the answer that is still counting out
  always_comb
  begin
    d = q;
    d.rsp.done = 1'b0;
    d.rsp.retry = 1'b0;
    unique case (q.st)
      HRIL_IDLE:
      begin
        if (take)
        begin
          if (collide)
          begin
            d.rsp.retry = 1'b1;
            d.rsp.rdata = 16'h0000;
          end
          else
          begin
            d.st = HRIL_BUSY;
            d.busy = 1'b1;
            d.cnt = 3'h1;
            d.mapped = is_int || is_mbx;
            d.rsp.rdata = req.write ? 16'h0000 : lane;
          end
        end
      end
      HRIL_BUSY:
      begin
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == DONE_AT)
        begin
          d.st = HRIL_IDLE;
          d.busy = 1'b0;
          d.rsp.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign busy = q.busy;
  assign rsp = q.rsp;

  // =====================================================================
  // Checks
  property p_fixed_span;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide |-> ##7 rsp.done;
  endproperty
  a_fixed_span: assert property (p_fixed_span)
    else $error("access did not finish in eight cycles");

  property p_no_early_done;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide |=> !rsp.done [*6];
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("access finished early");

  property p_collide_retry;
    @(posedge sys_clk) disable iff (!arst_n)
    take && collide |=> rsp.retry && !rsp.done && !busy;
  endproperty
  a_collide_retry: assert property (p_collide_retry)
    else $error("colliding read not retried");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    rsp.done && !q.mapped |-> rsp.rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_low_lane;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide && !req.write && req.be == 2'b01
      |-> ##7 rsp.rdata[15:8] == 8'h00;
  endproperty
  a_low_lane: assert property (p_low_lane)
    else $error("even byte access leaked high byte");

  property p_int_read;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !req.write && is_int && req.be == 2'b11
      |-> ##7 rsp.rdata == $past(int_val, 7);
  endproperty
  a_int_read: assert property (p_int_read)
    else $error("interrupt register read wrong");

  // =====================================================================
  // Access timing and read data path
  property p_busy_span;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide |=> busy [*6] ##1 !busy;
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy not high for six cycles then low");

  property p_done_idle;
    @(posedge sys_clk) disable iff (!arst_n)
    rsp.done |-> !busy;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("busy still high in done cycle");

  property p_single_done;
    @(posedge sys_clk) disable iff (!arst_n)
    rsp.done |=> !rsp.done;
  endproperty
  a_single_done: assert property (p_single_done)
    else $error("done lasted more than one cycle");

  property p_retry_cause;
    @(posedge sys_clk) disable iff (!arst_n)
    rsp.retry |-> $past(collide);
  endproperty
  a_retry_cause: assert property (p_retry_cause)
    else $error("retry without a colliding read");

  property p_retry_no_data;
    @(posedge sys_clk) disable iff (!arst_n)
    rsp.retry |-> rsp.rdata == 16'h0000;
  endproperty
  a_retry_no_data: assert property (p_retry_no_data)
    else $error("retry carried data");

  property p_write_no_retry;
    @(posedge sys_clk) disable iff (!arst_n)
    take && req.write |=> !rsp.retry;
  endproperty
  a_write_no_retry: assert property (p_write_no_retry)
    else $error("write was retried");

  property p_high_lane;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide && !req.write && req.be == 2'b10
      |-> ##7 rsp.rdata[7:0] == 8'h00;
  endproperty
  a_high_lane: assert property (p_high_lane)
    else $error("odd byte access leaked low byte");

  property p_unmapped_read;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !req.write && !is_int && !is_mbx
      |-> ##7 rsp.rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unassigned address read not zero");

  property p_mbx_read;
    @(posedge sys_clk) disable iff (!arst_n)
    take && !collide && !req.write && is_mbx && req.be == 2'b11
      |-> ##7 rsp.rdata == $past(mbx_val, 7);
  endproperty
  a_mbx_read: assert property (p_mbx_read)
    else $error("buffer read returned wrong value");

  // =====================================================================
  // Interrupt register as seen through the access path
  property p_en_write;
    @(posedge sys_clk) disable iff (!arst_n)
    take && req.write && is_int && req.be[0]
      |=> int_val[`HRIL_INT_EN_BIT] == $past(req.wdata[`HRIL_INT_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write did not land");

  property p_other_write_ignored;
    @(posedge sys_clk) disable iff (!arst_n)
    take && req.write && !is_int && !irq_event
      |=> int_val == $past(int_val);
  endproperty
  a_other_write_ignored: assert property (p_other_write_ignored)
    else $error("write elsewhere changed interrupt register");

  property p_pend_set;
    @(posedge sys_clk) disable iff (!arst_n)
    irq_event |=> int_val[`HRIL_INT_PEND_BIT];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("event did not set pending");

  property p_en_gate;
    @(posedge sys_clk) disable iff (!arst_n)
    !int_val[`HRIL_INT_EN_BIT] |-> !irq_req;
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("request raised while disabled");

endmodule // hril_top

// ---- tb/hril_host_model.sv ----
// Purpose: Host bus master issuing target accesses to the register block
// Assumes: One access at a time; lines change only at falling edges
// Notes: Released lines carry the inverse of the last value, not a stale copy
`timescale 1ns/10ps
module hril_host_model (
  input wire logic sys_clk,
  input wire logic busy,
  input wire hril_pkg::hril_rsp_type rsp,
  output hril_pkg::hril_req_type req
);
  import hril_pkg::*;
  // Cycles of the last access in which busy was seen high
  int busy_seen;
  // ==================================================
  // Idle bus at time zero
  initial
  begin
    req = '0;
  end

  // One access: hold until taken, release, then wait for done or retry
  task automatic access(input logic wr, input logic [11:0] a, input logic [1:0] be,
    input logic [15:0] wd, output logic [15:0] rd, output logic rty, output int cyc);
    int n;
    n = 0;
    @(negedge sys_clk);
    req = '{1'b1, wr, a, be, wd};
    @(posedge sys_clk);
    while (busy !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge sys_clk);
    end
    n = 0;
    busy_seen = 0;
    repeat (30)
    begin
      @(negedge sys_clk);
      n++;
      if (n == 1)
        req = '{1'b0, ~wr, ~a, ~be, ~wd};
      if (busy === 1'b1)
        busy_seen++;
      if (rsp.done === 1'b1 || rsp.retry === 1'b1)
        break;
    end
    rd = rsp.rdata;
    rty = rsp.retry;
    cyc = n + 1;
  endtask
endmodule // hril_host_model

// ---- tb/tb_host_register_interrupt_logic.sv ----
// Purpose: Self-checking bench for the host register block
// Assumes: Host model owns the request lines; bench drives the rest at falling edges
// Notes: Every access is also timed, so the fixed span is checked on every access but the colliding read
`timescale 1ns/10ps
`include "hril_params.svh"
module tb_host_register_interrupt_logic;
  import hril_pkg::*;
  logic sys_clk, arst_n, irq_event, diff_mode, busy, irq_req, rty;
  hril_req_type req;
  hril_conv_type conv;
  hril_rsp_type rsp;
  logic [15:0] rd;
  int err_total, checks, cycles, cyc;
  // Unassigned places, one of them inside the buffer range
  logic [11:0] holes [5] = '{12'h004, 12'h07e, 12'h0fe, 12'h100, 12'hffc};

  hril_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .conv(conv),
    .irq_event(irq_event), .diff_mode(diff_mode), .busy(busy), .rsp(rsp), .irq_req(irq_req));
  hril_host_model u_host (.sys_clk(sys_clk), .busy(busy), .rsp(rsp), .req(req));

  // ==================================================
  // Clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      test_done();
    end
  end

  // ==================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic rw(input logic wr, input logic [11:0] a, input logic [1:0] be,
    input logic [15:0] wd, input logic [15:0] exp);
    u_host.access(wr, a, be, wd, rd, rty, cyc);
    chk("access span", 16'h0008, cyc[15:0]);
    chk("busy span", 16'h0006, u_host.busy_seen[15:0]);
    chk("retry", 16'h0000, {15'h0000, rty});
    if (wr === 1'b0)
      chk("read data", exp, rd);
  endtask
  task automatic pulse;
    @(negedge sys_clk);
    irq_event = 1'b1;
    @(negedge sys_clk);
    irq_event = 1'b0;
  endtask
  task automatic conv_put(input logic [4:0] ch, input logic [15:0] d);
    @(negedge sys_clk);
    conv = '{1'b1, ch, d};
    @(negedge sys_clk);
    conv.valid = 1'b0;
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==================================================
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    irq_event = 1'b0;
    diff_mode = 1'b0;
    conv = '0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    chk("irq after reset", 16'h0000, {15'h0000, irq_req});
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0000);
    rw(1'b1, `HRIL_OFF_INT, 2'b11, 16'hffff, 16'h0000);
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0001);
    pulse();
    chk("irq raised", 16'h0001, {15'h0000, irq_req});
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0003);
    chk("irq held", 16'h0001, {15'h0000, irq_req});
    // Release through the odd byte lane only
    rw(1'b1, 12'h001, 2'b10, 16'h8000, 16'h0000);
    chk("irq released", 16'h0000, {15'h0000, irq_req});
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0001);
    // Disable drops the request but keeps pending
    pulse();
    rw(1'b1, `HRIL_OFF_INT, 2'b01, 16'h0000, 16'h0000);
    chk("irq disabled", 16'h0000, {15'h0000, irq_req});
    rw(1'b1, 12'h001, 2'b10, 16'h0001, 16'h0000);
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0002);
    rw(1'b1, `HRIL_OFF_INT, 2'b01, 16'h0001, 16'h0000);
    chk("irq reenabled", 16'h0001, {15'h0000, irq_req});
    rw(1'b0, `HRIL_OFF_INT, 2'b01, 16'h0000, 16'h0003);
    rw(1'b1, `HRIL_OFF_INT, 2'b11, 16'h8001, 16'h0000);
    chk("irq cleared", 16'h0000, {15'h0000, irq_req});
    // Event and release in one cycle: the event wins
    fork
      rw(1'b1, `HRIL_OFF_INT, 2'b10, 16'h8000, 16'h0000);
      pulse();
    join
    chk("event beats release", 16'h0001, {15'h0000, irq_req});
    rw(1'b1, `HRIL_OFF_INT, 2'b10, 16'h8000, 16'h0000);
    chk("irq released again", 16'h0000, {15'h0000, irq_req});
    // Unassigned places read zero
    foreach (holes[i])
      rw(1'b0, holes[i], 2'b11, 16'h0000, 16'h0000);
    // Single ended: one deep, read does not clear; byte lanes
    conv_put(5'h03, 16'h1234);
    rw(1'b0, 12'h08c, 2'b11, 16'h0000, 16'h1234);
    rw(1'b0, 12'h08c, 2'b01, 16'h0000, 16'h0034);
    rw(1'b0, 12'h08d, 2'b10, 16'h0000, 16'h1200);
    conv_put(5'h1f, 16'h9abc);
    rw(1'b0, 12'h0fd, 2'b10, 16'h0000, 16'h9a00);
    // Read colliding with a hardware write is refused, then retried
    fork
      u_host.access(1'b0, 12'h08c, 2'b11, 16'h0000, rd, rty, cyc);
      conv_put(5'h03, 16'h5678);
    join
    chk("collision retry", 16'h0001, {15'h0000, rty});
    chk("retry span", 16'h0002, cyc[15:0]);
    chk("retry busy", 16'h0000, u_host.busy_seen[15:0]);
    rw(1'b0, 12'h08c, 2'b11, 16'h0000, 16'h5678);
    // Differential: two deep
    diff_mode = 1'b1;
    conv_put(5'h05, 16'haaaa);
    conv_put(5'h05, 16'hbbbb);
    rw(1'b0, 12'h094, 2'b11, 16'h0000, 16'haaaa);
    rw(1'b0, 12'h094, 2'b11, 16'h0000, 16'hbbbb);
    rw(1'b0, 12'h094, 2'b11, 16'h0000, 16'hbbbb);
    // Full differential buffer drops its oldest value
    conv_put(5'h06, 16'h1111);
    conv_put(5'h06, 16'h2222);
    conv_put(5'h06, 16'h3333);
    rw(1'b0, 12'h098, 2'b11, 16'h0000, 16'h2222);
    rw(1'b0, 12'h098, 2'b11, 16'h0000, 16'h3333);
    // Reset in mid-run clears a raised request
    rw(1'b1, `HRIL_OFF_INT, 2'b01, 16'h0001, 16'h0000);
    pulse();
    chk("irq before reset", 16'h0001, {15'h0000, irq_req});
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    chk("irq after mid reset", 16'h0000, {15'h0000, irq_req});
    rw(1'b0, `HRIL_OFF_INT, 2'b11, 16'h0000, 16'h0000);
    test_done();
  end
endmodule // tb_host_register_interrupt_logic
